// ### logic/lfwd_pkg.sv
/*
 file holds the constants, carrier types and register map of the low-frequency
 countdown watchdog.
 assumes a single 250 MHz clock domain; the 32.768 kHz tick arrives as a pin and is
 synchronised inside the watchdog.
*/
// Contract
// - while running, writes to reload value, reload enables and setup are ignored.
// - counter counts down; wrapping past zero sets the expiry flag.
// - start loads the counter from the reload value register.
// - a granted reload loads the counter from the reload value register.
// - counter decrements once per low-frequency tick; timeout is (value+1)/32768 s.
// - while running, request the RC oscillator unless another source makes the clock.
// - eight reload requests; reload granted once key written to every enabled one.
// - a reload request counts only if its enable bit is set.
// - setup can pause counting during CPU sleep and during debugger halt.
// - entering off mode stops the watchdog and returns it to the unstarted state.
// - every expiry produces a reset request to the reset controller, unless a stop during the delay or off-mode entry cancels it.
// - with expiry interrupt enabled, reset request waits two low-frequency ticks.
// - a pending reset request is always issued unless a stop succeeds first; off-mode entry also cancels it.
// - a reset returns the watchdog to unlocked, writable configuration.
// - stop task is ignored unless stop allow was set in setup.
// - stop needs the key in stop unlock, stop allowed, then the stop task.
// - a successful stop sets the halted flag and halts counting.
// - a successful stop unlocks reload value, enables and setup.
// - irq enable set writes one to enable; reads show enables.
// - route registers hold a channel index and enable; enabled channel fires the task.
package lfwd_pkg;

   // ==========================================================
   // register offsets
   localparam logic [11:0] OFS_START_TRIGGER    = 12'h000;
   localparam logic [11:0] OFS_STOP_TRIGGER     = 12'h004;
   localparam logic [11:0] OFS_START_ROUTE      = 12'h080;
   localparam logic [11:0] OFS_STOP_ROUTE       = 12'h084;
   localparam logic [11:0] OFS_EXPIRY_FLAG      = 12'h100;
   localparam logic [11:0] OFS_HALTED_FLAG      = 12'h104;
   localparam logic [11:0] OFS_EXPIRY_ROUTE     = 12'h180;
   localparam logic [11:0] OFS_HALTED_ROUTE     = 12'h184;
   localparam logic [11:0] OFS_IRQ_EN_SET       = 12'h304;
   localparam logic [11:0] OFS_IRQ_EN_CLR       = 12'h308;
   localparam logic [11:0] OFS_NMI_EN_SET       = 12'h324;
   localparam logic [11:0] OFS_NMI_EN_CLR       = 12'h328;
   localparam logic [11:0] OFS_RUNNING_STATE    = 12'h400;
   localparam logic [11:0] OFS_RELOAD_PENDING   = 12'h404;
   localparam logic [11:0] OFS_RELOAD_VALUE     = 12'h504;
   localparam logic [11:0] OFS_RELOAD_REQ_EN    = 12'h508;
   localparam logic [11:0] OFS_SETUP            = 12'h50c;
   localparam logic [11:0] OFS_STOP_UNLOCK      = 12'h520;
   localparam logic [11:0] OFS_RELOAD_REQ_BASE  = 12'h600;

   // ==========================================================
   // field positions
   localparam int SETUP_SLEEP_RUN_BIT = 0;  // 1: keep counting in CPU sleep
   localparam int SETUP_HALT_RUN_BIT  = 3;  // 1: keep counting while debug halted
   localparam int SETUP_STOP_ALLOW_BIT = 6;
   localparam int IRQ_EXPIRY_BIT      = 0;
   localparam int IRQ_HALTED_BIT      = 1;
   localparam int ROUTE_EN_BIT        = 31;
   localparam int ROUTE_IDX_W         = 8;

   // ==========================================================
   // values after reset and constants
   localparam logic [31:0] RELOAD_VALUE_RESET = 32'hffffffff;
   localparam logic [7:0]  RELOAD_REQ_EN_RESET = 8'h01;
   localparam logic [31:0] SETUP_RESET        = 32'h00000001;
   localparam int          RELOAD_REQ_COUNT   = 8;
   localparam int          RESET_DELAY_TICKS  = 2;
   localparam real         LF_CLOCK_HZ        = 32768.0;
   localparam real         SYS_CLOCK_HZ       = 250.0e6;
   // key word; the value is arbitrary
   localparam logic [31:0] KEY_WORD_DEFAULT   = 32'h5a17c3e9;

   // ==========================================================
   // carrier types
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [11:0] adr;
      logic [31:0] dat;
   } lfwd_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } lfwd_wb_rsp_t;

   typedef struct packed {
      logic       cpuSleep;
      logic       debugHalt;
      logic       sysOffEntry;
      logic       otherLfRunning;
   } lfwd_sys_t;

endpackage : lfwd_pkg

// ### logic/lfwd_watchdog.sv
/*
 file holds the low-frequency countdown watchdog with its classic wishbone slave.
 assumes a synchronous active high reset, a 250 MHz clock, a raw 32.768 kHz clock pin
 and single-cycle channel pulses from the event interconnect.
*/
module lfwd_watchdog
   import lfwd_pkg::*;
#(
   parameter int          CHAN_COUNT = 256,
   parameter logic [31:0] KEY_WORD   = KEY_WORD_DEFAULT
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // register bus
   input  wire lfwd_wb_req_t          wbReq,
   output lfwd_wb_rsp_t               wbRsp,
   // low-frequency clock pin and system state
   input  wire logic                  lowFrequencyClock,
   input  wire lfwd_sys_t             sysState,
   // event interconnect
   input  wire logic [CHAN_COUNT-1:0] chanPulse,
   output logic [CHAN_COUNT-1:0]      chanPublish,
   // reset and clock control, interrupts
   output logic                       wdResetReq,
   output logic                       rcOscRequest,
   output logic                       irqOut,
   output logic                       nmiOut
);

   // ==========================================================
   // state
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_EXPIRED} lfwd_mode_t;

   typedef struct packed {
      lfwd_mode_t        mode;
      logic [2:0]        lfSync;
      logic [31:0]       counter;
      logic [31:0]       reloadValue;
      logic [7:0]        reloadReqEn;
      logic [7:0]        reloadPending;
      logic [31:0]       setup;
      logic [31:0]       stopUnlock;
      logic [31:0]       startRoute;
      logic [31:0]       stopRoute;
      logic [31:0]       expiryRoute;
      logic [31:0]       haltedRoute;
      logic              expiryFlag;
      logic              haltedFlag;
      logic [1:0]        irqEn;
      logic [1:0]        nmiEn;
      logic [1:0]        delayTicks;
      logic              resetReq;
      logic              ack;
      logic [31:0]       rdData;
      logic [CHAN_COUNT-1:0] publish;
   } lfwd_state_t;

   lfwd_state_t st;
   lfwd_state_t next_st;

   // byte-lane merge of a write into an old value
   function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // channel selected by a route register, when enabled
   function automatic logic routeHit(input logic [31:0] route,
                                     input logic [CHAN_COUNT-1:0] pulses);
      logic [ROUTE_IDX_W-1:0] idx;
      idx = route[ROUTE_IDX_W-1:0];
      return route[ROUTE_EN_BIT] && (32'(idx) < CHAN_COUNT) && pulses[idx];
   endfunction

   // ==========================================================
   // combinational next state
   always_comb begin
      logic        wrStrobe;
      logic        rdStrobe;
      logic [11:0] a;
      logic [31:0] wd;
      logic        running;
      logic        lfTick;
      logic        paused;
      logic        startTask;
      logic        stopTask;
      logic        grant;
      logic [7:0]  pendAfter;
      logic [31:0] rd;
      next_st   = st;
      a         = wbReq.adr;
      wrStrobe  = wbReq.cyc && wbReq.stb && wbReq.we && !st.ack;
      rdStrobe  = wbReq.cyc && wbReq.stb && !wbReq.we && !st.ack;
      wd        = laneMerge(32'h00000000, wbReq.dat, wbReq.sel);
      running   = (st.mode != ST_IDLE);
      startTask = 1'b0;
      stopTask  = 1'b0;
      grant     = 1'b0;
      rd        = 32'h00000000;
      lfTick    = 1'b0;
      paused    = 1'b0;
      pendAfter = 8'h00;
      next_st.publish = '0;
      next_st.ack     = wbReq.cyc && wbReq.stb && !st.ack;

      // tick on rising edge of the synchronised low-frequency clock
      next_st.lfSync = {st.lfSync[1:0], lowFrequencyClock};
      lfTick = st.lfSync[1] && !st.lfSync[2];
      paused = (sysState.cpuSleep && !st.setup[SETUP_SLEEP_RUN_BIT])
               || (sysState.debugHalt && !st.setup[SETUP_HALT_RUN_BIT]);

      // register writes
      if (wrStrobe) begin
         unique case (a)
            OFS_START_TRIGGER:  startTask = wd[0];
            OFS_STOP_TRIGGER:   stopTask  = wd[0];
            OFS_START_ROUTE:    next_st.startRoute  = laneMerge(st.startRoute, wbReq.dat,
                                                                wbReq.sel);
            OFS_STOP_ROUTE:     next_st.stopRoute   = laneMerge(st.stopRoute, wbReq.dat,
                                                                wbReq.sel);
            OFS_EXPIRY_ROUTE:   next_st.expiryRoute = laneMerge(st.expiryRoute, wbReq.dat,
                                                                wbReq.sel);
            OFS_HALTED_ROUTE:   next_st.haltedRoute = laneMerge(st.haltedRoute, wbReq.dat,
                                                                wbReq.sel);
            OFS_EXPIRY_FLAG:    if (wbReq.sel[0] && !wd[0]) next_st.expiryFlag = 1'b0;
            OFS_HALTED_FLAG:    if (wbReq.sel[0] && !wd[0]) next_st.haltedFlag = 1'b0;
            OFS_IRQ_EN_SET:     next_st.irqEn = st.irqEn | wd[1:0];
            OFS_IRQ_EN_CLR:     next_st.irqEn = st.irqEn & ~wd[1:0];
            OFS_NMI_EN_SET:     next_st.nmiEn = st.nmiEn | wd[1:0];
            OFS_NMI_EN_CLR:     next_st.nmiEn = st.nmiEn & ~wd[1:0];
            OFS_RELOAD_VALUE:   if (!running) next_st.reloadValue =
                                   laneMerge(st.reloadValue, wbReq.dat, wbReq.sel);
            OFS_RELOAD_REQ_EN:  if (!running && wbReq.sel[0])
                                   next_st.reloadReqEn = wbReq.dat[7:0];
            OFS_SETUP:          if (!running) next_st.setup =
                                   laneMerge(st.setup, wbReq.dat, wbReq.sel);
            OFS_STOP_UNLOCK:    next_st.stopUnlock = laneMerge(st.stopUnlock, wbReq.dat,
                                                               wbReq.sel);
            default: begin
               // reload request words; only a full-word key counts
               if (a[11:5] == OFS_RELOAD_REQ_BASE[11:5] && a[1:0] == 2'b00
                   && running && wbReq.sel == 4'hf && wbReq.dat == KEY_WORD
                   && st.reloadReqEn[a[4:2]]) begin
                  next_st.reloadPending[a[4:2]] = 1'b0;
               end
            end
         endcase
      end

      // tasks from the interconnect
      if (routeHit(st.startRoute, chanPulse)) startTask = 1'b1;
      if (routeHit(st.stopRoute, chanPulse)) stopTask = 1'b1;

      // reload grant once every enabled request holds the key
      pendAfter = next_st.reloadPending;
      if (running && st.mode == ST_RUN && pendAfter == 8'h00) begin
         grant = 1'b1;
         next_st.counter       = st.reloadValue;
         next_st.reloadPending = st.reloadReqEn;
      end

      // countdown and expiry
      if (st.mode == ST_RUN && lfTick && !paused && !grant) begin
         next_st.counter = st.counter - 32'h00000001;
         if (st.counter == 32'h00000000) begin
            next_st.mode       = ST_EXPIRED;
            next_st.expiryFlag = 1'b1;
            next_st.publish[st.expiryRoute[ROUTE_IDX_W-1:0]] = st.expiryRoute[ROUTE_EN_BIT];
            next_st.delayTicks = st.irqEn[IRQ_EXPIRY_BIT] ?
                                 2'(RESET_DELAY_TICKS) : 2'd0;
         end
      end

      // reset request after the optional delay
      if (st.mode == ST_EXPIRED) begin
         if (st.delayTicks == 2'd0) begin
            next_st.resetReq = 1'b1;
         end else if (lfTick) begin
            next_st.delayTicks = st.delayTicks - 2'd1;
         end
      end

      // start task loads the counter
      if (startTask && st.mode == ST_IDLE) begin
         next_st.mode          = ST_RUN;
         next_st.counter       = st.reloadValue;
         next_st.reloadPending = st.reloadReqEn;
      end

      // keyed stop, only when allowed; also ends a pending reset
      if (stopTask && running && st.setup[SETUP_STOP_ALLOW_BIT]
          && st.stopUnlock == KEY_WORD && !st.resetReq) begin
         next_st.mode       = ST_IDLE;
         next_st.haltedFlag = 1'b1;
         next_st.delayTicks = 2'd0;
         next_st.publish[st.haltedRoute[ROUTE_IDX_W-1:0]] = st.haltedRoute[ROUTE_EN_BIT];
      end

      // off mode stops and disables
      if (sysState.sysOffEntry) begin
         next_st.mode       = ST_IDLE;
         next_st.delayTicks = 2'd0;
         next_st.resetReq   = 1'b0;
      end

      // read mux
      if (rdStrobe) begin
         unique case (a)
            OFS_START_ROUTE:    rd = st.startRoute;
            OFS_STOP_ROUTE:     rd = st.stopRoute;
            OFS_EXPIRY_FLAG:    rd = {31'h0, st.expiryFlag};
            OFS_HALTED_FLAG:    rd = {31'h0, st.haltedFlag};
            OFS_EXPIRY_ROUTE:   rd = st.expiryRoute;
            OFS_HALTED_ROUTE:   rd = st.haltedRoute;
            OFS_IRQ_EN_SET,
            OFS_IRQ_EN_CLR:     rd = {30'h0, st.irqEn};
            OFS_NMI_EN_SET,
            OFS_NMI_EN_CLR:     rd = {30'h0, st.nmiEn};
            OFS_RUNNING_STATE:  rd = {31'h0, running};
            OFS_RELOAD_PENDING: rd = {24'h0, st.reloadPending};
            OFS_RELOAD_VALUE:   rd = st.reloadValue;
            OFS_RELOAD_REQ_EN:  rd = {24'h0, st.reloadReqEn};
            OFS_SETUP:          rd = st.setup;
            OFS_STOP_UNLOCK:    rd = st.stopUnlock;
            default:            rd = 32'h00000000;
         endcase
      end
      next_st.rdData = rd;
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st             <= '0;
         st.mode        <= ST_IDLE;
         st.reloadValue <= RELOAD_VALUE_RESET;
         st.reloadReqEn <= RELOAD_REQ_EN_RESET;
         st.setup       <= SETUP_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs
   assign wbRsp.ack    = st.ack;
   assign wbRsp.dat    = st.rdData;
   assign chanPublish  = st.publish;
   assign wdResetReq   = st.resetReq;
   assign rcOscRequest = (st.mode != ST_IDLE) && !sysState.otherLfRunning;
   assign irqOut       = (st.expiryFlag && st.irqEn[IRQ_EXPIRY_BIT])
                         || (st.haltedFlag && st.irqEn[IRQ_HALTED_BIT]);
   assign nmiOut       = (st.expiryFlag && st.nmiEn[IRQ_EXPIRY_BIT])
                         || (st.haltedFlag && st.nmiEn[IRQ_HALTED_BIT]);

endmodule // lfwd_watchdog

// ### sim/lfwd_assertions.sv
/*
 checker of the watchdog port behaviour, bound to the top module.
 assumes the design package and one clock with a synchronous active high reset.
*/
module lfwd_assertions
   import lfwd_pkg::*;
#(
   parameter int CHAN_COUNT = 256
) (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  sys_rst,
   // watched ports
   input wire lfwd_wb_req_t          wbReq,
   input wire lfwd_wb_rsp_t          wbRsp,
   input wire lfwd_sys_t             sysState,
   input wire logic                  lowFrequencyClock,
   input wire logic [CHAN_COUNT-1:0] chanPulse,
   input wire logic [CHAN_COUNT-1:0] chanPublish,
   input wire logic                  wdResetReq,
   input wire logic                  rcOscRequest,
   input wire logic                  irqOut
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // bus steps and helper count of slow clock rises since the interrupt rose
   sequence sReq; wbReq.cyc && wbReq.stb && !wbRsp.ack; endsequence
   sequence sAck; wbRsp.ack ##1 !wbRsp.ack; endsequence
   logic [7:0] sinceIrq;
   always_ff @(posedge clk) begin
      if (sys_rst || $rose(irqOut)) sinceIrq <= 8'h00;
      else if ($rose(lowFrequencyClock) && sinceIrq != 8'hff) sinceIrq <= sinceIrq + 8'h01;
   end
   // ==========================================================
   // properties
   chk_bus_answer: assert property (sReq |=> sAck)
      else $error("bus request not answered by one ack pulse");
   chk_osc_other: assert property (rcOscRequest |-> !sysState.otherLfRunning)
      else $error("oscillator requested while another source runs");
   chk_osc_hold: assert property (rcOscRequest && !sysState.sysOffEntry && !(|chanPulse)
      && !(wbReq.cyc && wbReq.stb && wbReq.we) |=> rcOscRequest || sysState.otherLfRunning)
      else $error("oscillator request dropped while running");
   chk_reset_held: assert property (wdResetReq && !sysState.sysOffEntry |=> wdResetReq)
      else $error("reset request dropped");
   chk_off_idle: assert property (sysState.sysOffEntry |=> !rcOscRequest)
      else $error("still running after off entry");
   chk_off_reset: assert property (sysState.sysOffEntry |=> !wdResetReq)
      else $error("reset request kept after off entry");
   chk_reset_release: assert property ($fell(sys_rst) |-> !wdResetReq && !rcOscRequest)
      else $error("not idle after reset");
   chk_publish_pulse: assert property (|chanPublish |=> !(|chanPublish))
      else $error("publish pulse longer than one cycle");
   chk_reset_delay: assert property ($rose(wdResetReq) && irqOut |-> sinceIrq >= 8'h02)
      else $error("reset request too soon after interrupt");
endmodule // lfwd_assertions

bind lfwd_watchdog lfwd_assertions #(.CHAN_COUNT(CHAN_COUNT)) uChk (.clk(clk),
   .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp), .sysState(sysState),
   .lowFrequencyClock(lowFrequencyClock), .chanPulse(chanPulse),
   .chanPublish(chanPublish), .wdResetReq(wdResetReq), .rcOscRequest(rcOscRequest),
   .irqOut(irqOut));

// ### sim/lfwd_clock_reset_model.sv
/*
 model of the clock control and reset controller beside the watchdog.
 assumes the bench's system clock; the slow clock is free running and unrelated to it.
*/
module lfwd_clock_reset_model #(
   parameter real HALF_NS = 81.0
) (
   // system clock and source choice
   input  wire logic clk,
   input  wire logic useOther,
   // watchdog side
   input  wire logic wdResetReq,
   output logic      lowFrequencyClock,
   output logic      otherLfRunning,
   output int        resetCount
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wdLast     = 1'b0;
   logic lfLevel    = 1'b0;
   logic otherLevel = 1'b0;
   int   pulseCount = 0;
   // one driver per output
   assign lowFrequencyClock = lfLevel;
   assign otherLfRunning    = otherLevel;
   assign resetCount        = pulseCount;
   // free running slow clock, shortened period
   always #(HALF_NS) lfLevel = ~lfLevel;
   // source state and reset request count, changed after the clock edge
   always @(posedge clk) begin
      otherLevel <= useOther;
      wdLast <= wdResetReq;
      if (wdResetReq && !wdLast) pulseCount <= pulseCount + 1;
   end
endmodule // lfwd_clock_reset_model

// ### sim/lfwd_watchdog_tb.sv
/*
 self-checking bench of the watchdog: bus tasks, read monitor and scenarios.
 assumes the design package, the partner model and the bound checker.
*/
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin errCount++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module lfwd_watchdog_tb
   import lfwd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] KEY = 32'h3c96a5f0; // key word; the value is arbitrary
   localparam int LF_CYC = 41;                // system cycles per slow tick
   logic         clk = 1'b0;
   logic         sys_rst = 1'b1;
   lfwd_wb_req_t wbReq = '0;
   lfwd_wb_rsp_t wbRsp;
   lfwd_sys_t    sysState;
   logic         sleep = 1'b0, halt = 1'b0, offEntry = 1'b0, useOther = 1'b0;
   logic         otherLf, low_frequency_clock, wdResetReq, rcOscRequest, irqOut, nmiOut;
   logic [255:0] chanPulse = '0, chanPublish;
   logic [31:0]  expQ[$];
   logic [31:0]  rv, expD;
   int           errCount = 0, totalChecks = 0, cycles = 0, resets, n, pubCount = 0;
   int           seed = 32'h4d81;
   assign sysState = {sleep, halt, offEntry, otherLf};
   // ==========================================================
   // design and partner
   lfwd_watchdog #(.KEY_WORD(KEY)) dut (.clk(clk), .sys_rst(sys_rst), .wbReq(wbReq),
      .wbRsp(wbRsp), .lowFrequencyClock(low_frequency_clock), .sysState(sysState), .chanPulse(chanPulse),
      .chanPublish(chanPublish), .wdResetReq(wdResetReq), .rcOscRequest(rcOscRequest),
      .irqOut(irqOut), .nmiOut(nmiOut));
   lfwd_clock_reset_model uPart (.clk(clk), .useOther(useOther), .wdResetReq(wdResetReq),
      .lowFrequencyClock(low_frequency_clock), .otherLfRunning(otherLf), .resetCount(resets));
   // clock and hang limit
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errCount++;
         finishTest();
      end
   end
   // read monitor takes the oldest expected value at each read answer; counts channel 3 pulses
   always @(negedge clk) begin
      if (chanPublish[3] === 1'b1) pubCount++;
      if (wbRsp.ack === 1'b1 && wbReq.we === 1'b0) begin
         expD = expQ.pop_front();
         `CHK(wbRsp.dat, expD)
      end
   end
   // ==========================================================
   // tasks
   task finishTest();
      $display("checks %0d mismatches %0d", totalChecks, errCount);
      if (errCount == 0 && totalChecks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task wbXfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
      do @(negedge clk); while (wbRsp.ack !== 1'b1);
      @(posedge clk);
      wbReq.cyc <= 1'b0;
      wbReq.stb <= 1'b0;
   endtask
   task wbWr(input logic [11:0] a, input logic [31:0] d); wbXfer(a, 1'b1, d); endtask
   task wbRd(input logic [11:0] a, input logic [31:0] e);
      expQ.push_back(e);
      wbXfer(a, 1'b0, 32'h0);
   endtask
   task doReset();
      @(posedge clk) sys_rst <= 1'b1;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
   endtask
   task waitReset(input int lim);
      n = 0;
      while (wdResetReq !== 1'b1 && n < lim) begin @(negedge clk); n++; end
   endtask
   // ==========================================================
   // scenarios
   initial begin
      doReset();
      wbRd(OFS_RELOAD_VALUE, 32'hffffffff);
      wbRd(OFS_RELOAD_REQ_EN, 32'h1);
      wbRd(OFS_SETUP, 32'h1);
      wbRd(12'h010, 32'h0);
      wbRd(OFS_START_TRIGGER, 32'h0);
      // counting, lock and reload
      rv = 32'h3 + ($random(seed) & 32'h3);
      wbWr(OFS_RELOAD_VALUE, rv);
      wbWr(OFS_RELOAD_REQ_EN, 32'h3);
      wbWr(OFS_SETUP, 32'h41);
      wbWr(OFS_START_TRIGGER, 32'h1);
      wbRd(OFS_RUNNING_STATE, 32'h1);
      wbWr(OFS_RELOAD_VALUE, $random(seed));
      wbRd(OFS_RELOAD_VALUE, rv);
      `CHK(rcOscRequest, 1'b1)
      useOther <= 1'b1;
      repeat (3) @(negedge clk);
      `CHK(rcOscRequest, 1'b0)
      useOther <= 1'b0;
      repeat (3 * rv) begin
         wbWr(OFS_RELOAD_REQ_BASE, KEY);
         wbWr(OFS_RELOAD_REQ_BASE + 12'h4, KEY);
         repeat (LF_CYC - 12) @(posedge clk);
      end
      `CHK(wdResetReq, 1'b0)
      wbWr(OFS_RELOAD_REQ_BASE, KEY);
      waitReset((rv + 2) * LF_CYC + 20);
      `CHK(n > rv * LF_CYC - 50 && wdResetReq === 1'b1, 1'b1)
      wbRd(OFS_EXPIRY_FLAG, 32'h1);
      `CHK(resets, 1)
      doReset();
      wbWr(OFS_RELOAD_VALUE, 32'h1);
      wbRd(OFS_RELOAD_VALUE, 32'h1);
      // delayed reset with the expiry interrupt on
      wbWr(OFS_IRQ_EN_SET, 32'h1);
      wbRd(OFS_IRQ_EN_SET, 32'h1);
      wbWr(OFS_START_TRIGGER, 32'h1);
      n = 0;
      while (irqOut !== 1'b1 && n < 300) begin @(negedge clk); n++; end
      waitReset(3 * LF_CYC);
      `CHK(n >= 2 * LF_CYC - 4 && n <= 2 * LF_CYC + 8, 1'b1)
      `CHK(irqOut, 1'b1)
      wbWr(OFS_NMI_EN_SET, 32'h1);
      `CHK(nmiOut, 1'b1)
      doReset();
      // refused stop, off entry, then a granted stop
      wbWr(OFS_START_TRIGGER, 32'h1);
      wbWr(OFS_STOP_UNLOCK, KEY);
      wbWr(OFS_STOP_TRIGGER, 32'h1);
      wbRd(OFS_RUNNING_STATE, 32'h1);
      @(posedge clk) offEntry <= 1'b1;
      @(posedge clk) offEntry <= 1'b0;
      wbRd(OFS_RUNNING_STATE, 32'h0);
      wbWr(OFS_HALTED_ROUTE, 32'h80000003);
      wbWr(OFS_SETUP, 32'h41);
      wbWr(OFS_RELOAD_VALUE, 32'h7);
      wbWr(OFS_START_TRIGGER, 32'h1);
      wbWr(OFS_STOP_TRIGGER, 32'h1);
      wbRd(OFS_HALTED_FLAG, 32'h1);
      `CHK(pubCount, 1)
      wbRd(OFS_RUNNING_STATE, 32'h0);
      wbWr(OFS_RELOAD_VALUE, 32'h9);
      wbRd(OFS_RELOAD_VALUE, 32'h9);
      wbWr(OFS_STOP_UNLOCK, 32'h0);
      wbWr(OFS_HALTED_FLAG, 32'h0);
      wbRd(OFS_HALTED_FLAG, 32'h0);
      repeat (12 * LF_CYC) @(posedge clk);
      `CHK(wdResetReq, 1'b0)
      // channel start, pause in sleep and in debug halt
      doReset();
      wbWr(OFS_RELOAD_VALUE, 32'h2);
      wbWr(OFS_SETUP, 32'h0);
      wbWr(OFS_START_ROUTE, 32'h80000005);
      sleep <= 1'b1;
      @(posedge clk) chanPulse[5] <= 1'b1;
      @(posedge clk) chanPulse[5] <= 1'b0;
      wbRd(OFS_RUNNING_STATE, 32'h1);
      repeat (6 * LF_CYC) @(posedge clk);
      sleep <= 1'b0;
      halt <= 1'b1;
      repeat (6 * LF_CYC) @(posedge clk);
      `CHK(wdResetReq, 1'b0)
      halt <= 1'b0;
      waitReset(4 * LF_CYC + 10);
      `CHK(wdResetReq, 1'b1)
      finishTest();
   end
endmodule // lfwd_watchdog_tb
